// >>> verif/pwmoc_gate_model.sv
// gate driver model: registers the pin levels it receives from the output stage
`timescale 1ns/1ns
module pwmoc_gate_model (
    input wire logic clk_i,
    input wire logic high_i,
    input wire logic low_i,
    output logic high_seen_o,
    output logic low_seen_o
);
    // drivers latch the pin level each cycle, no filtering of glitches
    always_ff @(posedge clk_i) begin
        high_seen_o <= high_i;
        low_seen_o <= low_i;
    end
endmodule : pwmoc_gate_model

// >>> verif/testbench.sv
// self-checking bench of the pwm output stage against an integer model
`timescale 1ns/1ns
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin miscompares++; $display("MISMATCH t=%0t %s", $time, m); end end
module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b1, lock = 1'b0;
    logic gh = 1'b0, gl = 1'b0, cl = 1'b0, ph = 1'b0, pl = 1'b0, ack, err, hso, lso, chop, lko, hs, ls;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h00000000, rdat;
    logic [15:0] mdo, pc, mdl;
    logic [1:0] pmo;
    int miscompares = 0, cmp_count = 0, seed = 22, n, i;
    logic [31:0] r;
    logic e;
    // free-running clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    pwmoc_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .err_o(err), .prescale_tick_i(tick),
        .pwm_module_enable_i(1'b0), .lock_config_i(lock), .gen_high_i(gh), .gen_low_i(gl), .current_limit_i(cl),
        .fault_i(1'b0), .gpio_high_i(ph), .gpio_low_i(pl), .high_side_output_o(hso), .low_side_output_o(lso),
        .chop_clk_o(chop), .master_duty_o(mdo), .pin_pair_mode_o(pmo), .lock_active_o(lko));
    pwmoc_gate_model gates (.clk_i(clk_i), .high_i(hso), .low_i(lso), .high_seen_o(hs), .low_seen_o(ls));
    // one classic wishbone cycle, held until ack or err is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; dat <= {16'h0000, d};
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        r = rdat; e = err;
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wb
    // cycles until the chop output changes level
    task automatic chop_edge();
        logic c;
        c = chop; n = 0;
        do begin @(posedge clk_i); n++; end while (chop === c && n < 2000);
    endtask : chop_edge
    // expected pin pair; polarity applies after the source choice, ownership last
    function automatic logic [1:0] exp_pins(input logic [15:0] p, input logic h0, l0, c, gph, gpl);
        logic h, l;
        // pair mode shapes only the generator levels
        if (p[11:10] == 2'h0) l0 = ~h0;
        if (p[11:10] == 2'h3) begin h0 = 1'b0; l0 = 1'b0; end
        h = p[9] ? p[7] : h0;
        l = p[8] ? p[6] : l0;
        if (c) begin h = p[3]; l = p[2]; end
        h = (h ^ p[13]) & p[15] | gph & ~p[15];
        l = (l ^ p[12]) & p[14] | gpl & ~p[14];
        return {h, l};
    endfunction : exp_pins
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    // watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #500000;
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h8, 16'h0000); `CHK(r[15:0], 16'hC000, "pin control reset")
        wb(1'b0, 4'h0, 16'h0000); `CHK(r[15:0], 16'h0000, "chop reset")
        wb(1'b0, 4'h2, 16'h0000); `CHK(e, 1'b1, "unmapped address err")
        $display("test reset done");
        mdl = $random(seed);
        wb(1'b1, 4'h4, mdl); wb(1'b0, 4'h4, 16'h0000);
        `CHK(r[15:0], mdl, "duty readback")
        `CHK(mdo, mdl, "duty output")
        for (i = 0; i < 2; i++) begin
            wb(1'b1, 4'h0, 16'h8000 | (i * 5));
            chop_edge(); chop_edge();
            `CHK(n, i * 5 + 1, "chop half period")
        end
        wb(1'b1, 4'h0, 16'h0005);
        repeat (4) @(posedge clk_i);
        `CHK(chop, 1'b0, "chop stopped")
        $display("test chop done");
        for (i = 0; i < 40; i++) begin
            pc = ($random(seed) & 16'hF3FC) | (16'(i % 4) << 10);
            wb(1'b1, 4'h8, pc);
            gh <= $random(seed); gl <= $random(seed); ph <= $random(seed); pl <= $random(seed);
            cl <= (i % 3 != 2) ? 1'($random(seed)) : 1'b0;
            repeat (6) @(posedge clk_i);
            `CHK(pmo, pc[11:10], "pair mode field")
            `CHK({hso, lso}, exp_pins(pc, gh, gl, cl, ph, pl), "pin levels")
            `CHK({hs, ls}, {hso, lso}, "driver view")
        end
        cl <= 1'b0;
        $display("test pins done");
        lock <= 1'b1;
        wb(1'b1, 4'h8, 16'h0400); wb(1'b0, 4'h8, 16'h0000);
        `CHK(r[15:0], pc, "locked write ignored")
        `CHK(lko, 1'b1, "lock active")
        wb(1'b1, 4'hC, 16'hAA55); wb(1'b1, 4'hC, 16'h55AA);
        wb(1'b1, 4'h8, 16'hC400); wb(1'b1, 4'h8, 16'h0800); wb(1'b0, 4'h8, 16'h0000);
        `CHK(r[15:0], 16'hC400, "one write after unlock")
        $display("test lock done");
        give_verdict();
    end
endmodule : testbench

// >>> verilog/pwmoc_chop.sv
// chop clock divider: toggles at terminal count of a reloading counter
`timescale 1ns/1ns
module pwmoc_chop #(
    parameter int DIV_W = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic enable_i,
    input wire logic [DIV_W-1:0] divider_i,
    output logic chop_o
);
    logic [DIV_W-1:0] cnt_q;
    initial begin
        if (DIV_W < 1) $error("chop divider width must be positive");
    end
    // count prescaled ticks, reload on terminal count; disabled holds low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            chop_o <= 1'b0;
        end else if (ce_i) begin
            if (!enable_i) begin
                cnt_q <= divider_i;
                chop_o <= 1'b0;
            end else if (tick_i) begin
                if (cnt_q == '0) begin
                    cnt_q <= divider_i;
                    chop_o <= ~chop_o;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule : pwmoc_chop

// >>> verilog/pwmoc_pkg.sv
// package: register map, field layout and types of the pwm output pin control block
package pwmoc_pkg;
    // register byte offsets on the wishbone bus
    localparam logic [3:0] CHOP_OFF = 4'h0;
    localparam logic [3:0] MDC_OFF = 4'h4;
    localparam logic [3:0] PINCTL_OFF = 4'h8;
    localparam logic [3:0] UNLOCK_OFF = 4'hC;
    // chop register fields
    localparam int CHOP_EN_BIT = 15;
    localparam int CHOP_DIV_W = 10;
    // pin control register fields
    localparam int HIGH_OWN_BIT = 15;
    localparam int LOW_OWN_BIT = 14;
    localparam int HIGH_POL_BIT = 13;
    localparam int LOW_POL_BIT = 12;
    localparam int PMODE_LSB = 10;
    localparam int HIGH_OVR_BIT = 9;
    localparam int LOW_OVR_BIT = 8;
    localparam int OVR_DAT_LSB = 6;
    localparam int FLT_DAT_LSB = 4;
    localparam int CL_DAT_LSB = 2;
    localparam int SWAP_BIT = 1;
    localparam int OVERRIDE_SYNC_BIT = 0;
    // reset values
    localparam logic [15:0] CHOP_RST = 16'h0000;
    localparam logic [15:0] MDC_RST = 16'h0000;
    localparam logic [15:0] PINCTL_RST = 16'hC000;
    // unlock sequence keys
    localparam logic [15:0] UNLOCK_KEY1 = 16'hAA55;
    localparam logic [15:0] UNLOCK_KEY2 = 16'h55AA;
    localparam logic [1:0] PMODE_RESERVED = 2'h3;

    // pin pair drive from the generator and the pin outputs
    typedef struct packed {
        logic high;
        logic low;
    } pwmoc_pair_type;
endpackage : pwmoc_pkg

// >>> verilog/pwmoc_sync.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module pwmoc_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;
    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            q_o <= 1'b0;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : pwmoc_sync

// >>> verilog/pwmoc_top.sv
// pwm output stage: chop clock, master duty cycle and pin control behind wishbone
// How it works
// - chop enable bit 15 starts chop generator, clearing stops it.
// - chop clock toggles every divider field plus one prescaled ticks.
// - sixteen bit master duty cycle register, read and write.
// - ownership bit set gives pin to pwm, clear leaves gpio control.
// - polarity bit set makes pin active low, clear active high.
// - two bit pin pair mode field; code 11 is reserved.
// - during current limit with no fault active, pins take current limit data bits.
// - with lock option set, pin control writes need unlock sequence first.
// - pin control resets with both ownership bits one, rest zero.
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
module pwmoc_top #(
    parameter int DIV_W = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // classic wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // device context
    input wire logic prescale_tick_i,
    input wire logic pwm_module_enable_i,
    input wire logic lock_config_i,
    input wire logic gen_high_i,
    input wire logic gen_low_i,
    input wire logic current_limit_i,
    input wire logic fault_i,
    input wire logic gpio_high_i,
    input wire logic gpio_low_i,
    // outputs
    output logic high_side_output_o,
    output logic low_side_output_o,
    output logic chop_clk_o,
    output logic [15:0] master_duty_o,
    output logic [1:0] pin_pair_mode_o,
    output logic lock_active_o
);
    logic [15:0] chop_q;
    logic [15:0] mdc_q;
    logic [15:0] pinctl_q;
    logic [1:0] unlock_stage_q;
    logic unlocked_q;
    logic cl_sync;
    logic flt_sync;
    logic req;
    logic wr_ok;
    logic lane_lo;
    logic lane_hi;
    logic [15:0] wdat;
    logic [15:0] pin_wmask;
    logic mapped;
    logic pinctl_wr;
    pwmoc_pkg::pwmoc_pair_type gen_pair;
    pwmoc_pkg::pwmoc_pair_type drive_pair;
    pwmoc_pkg::pwmoc_pair_type out_d;

    initial begin
        if (DIV_W != 10) $error("chop divider field is fixed at ten bits");
    end

    // current limit and fault inputs come from outside the clock domain
    pwmoc_sync u_cl_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(current_limit_i),
        .q_o(cl_sync)
    );
    pwmoc_sync u_flt_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(fault_i),
        .q_o(flt_sync)
    );

    // bus decode; ack only on the first cycle so each access takes one edge
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign lane_lo = sel_i[0];
    assign lane_hi = sel_i[1];
    assign wdat = dat_i[15:0];
    assign mapped = (adr_i == pwmoc_pkg::CHOP_OFF) || (adr_i == pwmoc_pkg::MDC_OFF)
        || (adr_i == pwmoc_pkg::PINCTL_OFF) || (adr_i == pwmoc_pkg::UNLOCK_OFF);
    assign wr_ok = req && we_i && mapped;
    assign pinctl_wr = wr_ok && (adr_i == pwmoc_pkg::PINCTL_OFF)
        && (!lock_config_i || unlocked_q);
    assign pin_wmask = {{8{lane_hi}}, {8{lane_lo}}};

    // answer: ack for mapped, err for unmapped, one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= req && mapped;
            err_o <= req && !mapped;
        end
    end

    // read data captured with the answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            if (req && !we_i) begin
                if (adr_i == pwmoc_pkg::CHOP_OFF) begin
                    dat_o <= {16'h0000, chop_q};
                end else if (adr_i == pwmoc_pkg::MDC_OFF) begin
                    dat_o <= {16'h0000, mdc_q};
                end else if (adr_i == pwmoc_pkg::PINCTL_OFF) begin
                    dat_o <= {16'h0000, pinctl_q};
                end else if (adr_i == pwmoc_pkg::UNLOCK_OFF) begin
                    dat_o <= {30'h0000_0000, lock_active_o, unlocked_q};
                end else begin
                    dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    // chop register; bits 14-10 are unimplemented and read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chop_q <= pwmoc_pkg::CHOP_RST;
        end else if (ce_i && wr_ok && adr_i == pwmoc_pkg::CHOP_OFF) begin
            if (lane_lo) chop_q[7:0] <= wdat[7:0];
            if (lane_hi) chop_q[15:8] <= {wdat[pwmoc_pkg::CHOP_EN_BIT], 5'h00, wdat[9:8]};
        end
    end

    // master duty cycle storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mdc_q <= pwmoc_pkg::MDC_RST;
        end else if (ce_i && wr_ok && adr_i == pwmoc_pkg::MDC_OFF) begin
            if (lane_lo) mdc_q[7:0] <= wdat[7:0];
            if (lane_hi) mdc_q[15:8] <= wdat[15:8];
        end
    end

    // pin control; reset gives ownership to pwm, lock gates writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pinctl_q <= pwmoc_pkg::PINCTL_RST;
        end else if (ce_i && pinctl_wr) begin
            pinctl_q <= (pinctl_q & ~pin_wmask) | (wdat & pin_wmask);
        end
    end

    // unlock sequence: key1 then key2 opens one pin control write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlock_stage_q <= 2'h0;
            unlocked_q <= 1'b0;
        end else if (ce_i) begin
            if (wr_ok && adr_i == pwmoc_pkg::UNLOCK_OFF && sel_i[1:0] == 2'h3) begin
                if (wdat == pwmoc_pkg::UNLOCK_KEY1) begin
                    unlock_stage_q <= 2'h1;
                end else if (wdat == pwmoc_pkg::UNLOCK_KEY2 && unlock_stage_q == 2'h1) begin
                    unlock_stage_q <= 2'h0;
                    unlocked_q <= 1'b1;
                end else begin
                    unlock_stage_q <= 2'h0;
                end
            end else if (pinctl_wr) begin
                unlocked_q <= 1'b0; // one write per unlock
            end
        end
    end

    assign lock_active_o = lock_config_i && !unlocked_q;

    // chop clock divider
    pwmoc_chop #(
        .DIV_W(DIV_W)
    ) u_chop (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(prescale_tick_i),
        .enable_i(chop_q[pwmoc_pkg::CHOP_EN_BIT]),
        .divider_i(chop_q[DIV_W-1:0]),
        .chop_o(chop_clk_o)
    );

    // generator pair shaped by pair mode; reserved code drives both inactive
    always_comb begin
        gen_pair.high = gen_high_i;
        gen_pair.low = gen_low_i;
        case (pinctl_q[pwmoc_pkg::PMODE_LSB +: 2])
            2'h0: gen_pair.low = ~gen_high_i; // complementary
            2'h1: gen_pair.low = gen_low_i; // redundant/independent low
            2'h2: gen_pair.low = gen_low_i; // independent
            default: begin
                gen_pair.high = 1'b0;
                gen_pair.low = 1'b0;
            end
        endcase
        // swap exchanges the two shaped levels in one step
        if (pinctl_q[pwmoc_pkg::SWAP_BIT]) begin
            gen_pair = {gen_pair.low, gen_pair.high};
        end
    end

    // priority: fault, then current limit, then override, then generator
    always_comb begin
        drive_pair = gen_pair;
        if (pinctl_q[pwmoc_pkg::HIGH_OVR_BIT]) drive_pair.high = pinctl_q[pwmoc_pkg::OVR_DAT_LSB + 1];
        if (pinctl_q[pwmoc_pkg::LOW_OVR_BIT]) drive_pair.low = pinctl_q[pwmoc_pkg::OVR_DAT_LSB];
        if (cl_sync) begin
            drive_pair.high = pinctl_q[pwmoc_pkg::CL_DAT_LSB + 1];
            drive_pair.low = pinctl_q[pwmoc_pkg::CL_DAT_LSB];
        end
        if (flt_sync) begin
            drive_pair.high = pinctl_q[pwmoc_pkg::FLT_DAT_LSB + 1];
            drive_pair.low = pinctl_q[pwmoc_pkg::FLT_DAT_LSB];
        end
        out_d.high = pinctl_q[pwmoc_pkg::HIGH_OWN_BIT]
            ? drive_pair.high ^ pinctl_q[pwmoc_pkg::HIGH_POL_BIT] : gpio_high_i;
        out_d.low = pinctl_q[pwmoc_pkg::LOW_OWN_BIT]
            ? drive_pair.low ^ pinctl_q[pwmoc_pkg::LOW_POL_BIT] : gpio_low_i;
    end

    // registered pin drive avoids glitches at the gate driver
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_side_output_o <= 1'b0;
            low_side_output_o <= 1'b0;
        end else if (ce_i) begin
            high_side_output_o <= out_d.high;
            low_side_output_o <= out_d.low;
        end
    end

    assign master_duty_o = mdc_q;
    assign pin_pair_mode_o = pinctl_q[pwmoc_pkg::PMODE_LSB +: 2]; // pwm_module_enable_i unused

    // checks
    lock_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && lock_config_i && !unlocked_q) |=> $stable(pinctl_q))
        else $error("pin control changed while locked");
    reset_own_a: assert property (@(posedge clk_i)
        !rst_i && $past(rst_i) |-> pinctl_q == 16'hC000)
        else $error("pin control reset value wrong");
    mdc_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && wr_ok && adr_i == 4'h4 && sel_i[1:0] == 2'h3) |=> mdc_q == $past(dat_i[15:0]))
        else $error("master duty write lost");
    chop_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !chop_q[15]) |=> !chop_clk_o)
        else $error("chop runs while disabled");
    cl_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && cl_sync && !flt_sync && pinctl_q[15] && !pinctl_q[13])
        |=> high_side_output_o == $past(pinctl_q[3]))
        else $error("current limit high state wrong");
    ovr_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !cl_sync && !flt_sync && pinctl_q[14] && pinctl_q[8] && !pinctl_q[12])
        |=> low_side_output_o == $past(pinctl_q[6]))
        else $error("override low state wrong");
    gpio_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !pinctl_q[15]) |=> high_side_output_o == $past(gpio_high_i))
        else $error("gpio lost high pin");
    pol_invert_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && pinctl_q[14] && pinctl_q[12] && !pinctl_q[8] && !cl_sync && !flt_sync
        && pinctl_q[11:10] == 2'h2 && !pinctl_q[1]) |=> low_side_output_o == !$past(gen_low_i))
        else $error("low polarity wrong");
endmodule : pwmoc_top
